// *** core/hwh_device.sv ***
// device end of the wake-up / ready handshake
// assumes the command core reports acknowledged commands and rf events on sys_clk_i
`timescale 1ns/1ps
module hwh_device #(
	parameter int unsigned RESP_TIMEOUT = hwh_pkg::RESP_TIMEOUT_CYC, // interrupt timeout
	parameter int unsigned PD_SETTLE = hwh_pkg::PD_SETTLE_CYC, // entry into power-down
	parameter int unsigned OSC_START = hwh_pkg::OSC_START_CYC // oscillator start-up
) (
	input wire logic sys_clk_i, // system clock
	input wire logic resetn_i, // async reset, active low
	hwh_if.dev link, // handshake lines
	input wire logic cmd_ack_i, // pulse: a command was acknowledged
	input wire hwh_pkg::hwh_cmd_e cmd_kind_i, // kind of acknowledged command
	input wire logic rf_field_i, // level: external rf field present
	input wire logic link_rx_i, // pulse: data seen on the active host link
	input wire logic resp_ready_i, // pulse: response frame ready to go
	input wire logic sam_event_i, // pulse: secure module activity
	output logic resp_send_o, // pulse: start sending the response frame
	output logic asleep_o, // level: device is powered down
	output logic low_batt_o, // level: low-battery mode active
	output logic vcard_o // level: virtual card mode active
);
	import hwh_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		DV_AWAKE = 6'b00_0001,
		DV_PD_SETTLE = 6'b00_0010,
		DV_POWER_DOWN_CMD = 6'b00_0100,
		DV_OSC_START = 6'b00_1000,
		DV_RESP_IRQ = 6'b01_0000,
		DV_SAM_IRQ = 6'b10_0000
	} hwh_dev_state_e;

	typedef struct packed {
		hwh_dev_state_e st;
		logic [CNT_W-1:0] cnt;
		logic req_s1;
		logic req_s2;
		logic req_prev;
		logic irq_n;
		logic resp_send;
		logic asleep;
		logic low_batt;
		logic vcard;
	} hwh_dev_s;

	hwh_dev_s q;
	hwh_dev_s d;
	logic req_fall;
	logic req_low;
	logic pd_cmd;

	// counter load value, the count runs down to zero
	function automatic logic [CNT_W-1:0] cnt_load(input int unsigned cycles);
		cnt_load = CNT_W'(cycles - 1);
	endfunction

	// request line falling edge, taken only from the second sync stage onward
	assign req_fall = q.req_prev & ~q.req_s2;
	assign req_low = ~q.req_s2;

	// commands whose acknowledge sends the device to sleep
	always_comb begin
		pd_cmd = 1'b0;
		if (cmd_ack_i) begin
			case (cmd_kind_i)
				HWH_CMD_TARGET_INIT: pd_cmd = ~rf_field_i;
				HWH_CMD_SAM_LOWBAT: pd_cmd = ~rf_field_i;
				HWH_CMD_SAM_CARDEMU: pd_cmd = ~rf_field_i;
				HWH_CMD_SAM_VCARD: pd_cmd = ~rf_field_i;
				HWH_CMD_POWER_DOWN: pd_cmd = 1'b1;
				HWH_CMD_CPU_PD_VAR: pd_cmd = 1'b1;
				default: pd_cmd = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.resp_send = 1'b0;
		// two-stage sync of the request pin, then an edge register
		d.req_s1 = link.wake_req_n;
		d.req_s2 = q.req_s1;
		d.req_prev = q.req_s2;
		if (q.cnt != '0) begin
			d.cnt = q.cnt - 1'b1;
		end
		// mode flags follow the secure-module configuration
		if (cmd_ack_i) begin
			case (cmd_kind_i)
				HWH_CMD_SAM_LOWBAT: begin
					d.low_batt = 1'b1;
					d.vcard = 1'b0;
				end
				HWH_CMD_SAM_CARDEMU: begin
					d.low_batt = 1'b0;
					d.vcard = 1'b0;
				end
				HWH_CMD_SAM_VCARD: begin
					d.low_batt = 1'b0;
					d.vcard = 1'b1;
				end
				HWH_CMD_POWER_DOWN: d.vcard = 1'b0;
				default: d.vcard = q.vcard;
			endcase
		end
		case (q.st)
			DV_AWAKE: begin
				if (resp_ready_i) begin
					if (q.low_batt) begin
						d.resp_send = 1'b1;
					end else begin
						d.irq_n = LINE_ASSERTED;
						d.cnt = cnt_load(RESP_TIMEOUT);
						d.st = DV_RESP_IRQ;
					end
				end else if (sam_event_i && q.vcard && !q.low_batt) begin
					d.irq_n = LINE_ASSERTED;
					d.st = DV_SAM_IRQ;
				end else if (pd_cmd) begin
					d.cnt = cnt_load(PD_SETTLE);
					d.st = DV_PD_SETTLE;
				end
			end
			DV_PD_SETTLE: begin
				// commands in this window are not guarded; the host is told to hold off
				if (q.cnt == '0) begin
					d.asleep = 1'b1;
					d.st = DV_POWER_DOWN_CMD;
				end
			end
			DV_POWER_DOWN_CMD: begin
				if (resp_ready_i && !q.low_batt) begin
					// rf activation woke the core; report straight away
					d.asleep = 1'b0;
					d.irq_n = LINE_ASSERTED;
					d.cnt = cnt_load(RESP_TIMEOUT);
					d.st = DV_RESP_IRQ;
				end else if (sam_event_i && q.vcard && !q.low_batt) begin
					d.asleep = 1'b0;
					d.irq_n = LINE_ASSERTED;
					d.st = DV_SAM_IRQ;
				end else if (link_rx_i || (req_low && !q.low_batt) || rf_field_i) begin
					d.cnt = cnt_load(OSC_START);
					d.st = DV_OSC_START;
				end
			end
			DV_OSC_START: begin
				if (q.cnt == '0) begin
					d.asleep = 1'b0;
					d.st = DV_AWAKE;
				end
			end
			DV_RESP_IRQ: begin
				if (req_fall || q.cnt == '0) begin
					d.resp_send = 1'b1;
					d.irq_n = LINE_RELEASED;
					d.cnt = '0;
					d.st = DV_AWAKE;
				end
			end
			DV_SAM_IRQ: begin
				if (cmd_ack_i && cmd_kind_i == HWH_CMD_STATUS_QUERY) begin
					d.irq_n = LINE_RELEASED;
					d.st = DV_AWAKE;
				end
			end
			default: begin
				d.irq_n = LINE_RELEASED;
				d.st = DV_AWAKE;
			end
		endcase
		if (d.low_batt) begin
			d.irq_n = LINE_RELEASED;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// lines idle high from reset
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q.st <= DV_AWAKE;
			q.cnt <= '0;
			q.req_s1 <= LINE_RELEASED;
			q.req_s2 <= LINE_RELEASED;
			q.req_prev <= LINE_RELEASED;
			q.irq_n <= LINE_RELEASED;
			q.resp_send <= 1'b0;
			q.asleep <= 1'b0;
			q.low_batt <= 1'b0;
			q.vcard <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign link.host_irq_n = q.irq_n;
	assign resp_send_o = q.resp_send;
	assign asleep_o = q.asleep;
	assign low_batt_o = q.low_batt;
	assign vcard_o = q.vcard;

endmodule

// *** core/hwh_pkg.sv ***
// wake-up and ready handshake: shared constants, command kinds and timing counts
// assumes a single 250 MHz system clock on both ends
package hwh_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned CNT_W = 22;
	// longest interrupt pulse before the response goes out anyway
	localparam int unsigned RESP_TIMEOUT_MS = 12;
	localparam int unsigned RESP_TIMEOUT_CYC = RESP_TIMEOUT_MS * 1000 * CLK_MHZ;
	// settling time from a command response into power-down
	localparam int unsigned PD_SETTLE_MS = 1;
	localparam int unsigned PD_SETTLE_CYC = PD_SETTLE_MS * 1000 * CLK_MHZ;
	// oscillator start-up, worst case
	localparam int unsigned OSC_START_US = 2000;
	localparam int unsigned OSC_START_CYC = OSC_START_US * CLK_MHZ;
	// acknowledge pulse on the request line while the device is awake
	localparam int unsigned ACK_PULSE_US = 1;
	localparam int unsigned ACK_PULSE_CYC = ACK_PULSE_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// frame bytes the host side must honour
	// ----------------------------------------------------------------
	// host preamble and postamble byte
	localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
	localparam logic [31:0] VCARD_CFG_BYTES = 32'hD414_0200;
	localparam logic [15:0] STATUS_QUERY_BYTES = 16'hD404;

	// ----------------------------------------------------------------
	// reset values of the handshake lines (released = high)
	// ----------------------------------------------------------------
	localparam logic LINE_RELEASED = 1'b1;
	localparam logic LINE_ASSERTED = 1'b0;

	// ----------------------------------------------------------------
	// acknowledged command kinds reported by the device core
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		HWH_CMD_OTHER = 3'h0,
		HWH_CMD_TARGET_INIT = 3'h1,
		HWH_CMD_SAM_LOWBAT = 3'h2,
		HWH_CMD_SAM_CARDEMU = 3'h3,
		HWH_CMD_SAM_VCARD = 3'h4,
		HWH_CMD_POWER_DOWN = 3'h5,
		HWH_CMD_CPU_PD_VAR = 3'h6,
		HWH_CMD_STATUS_QUERY = 3'h7
	} hwh_cmd_e;

endpackage

// *** core/hwh_if.sv ***
// handshake lines between the transceiver and its host controller
// both lines are active low and idle high; each has a single driver
`timescale 1ns/1ps
interface hwh_if;
	logic host_irq_n; // device to host request line
	logic wake_req_n; // host to device wake / acknowledge line

	modport dev (output host_irq_n, input wake_req_n);
	modport host (input host_irq_n, output wake_req_n);
endinterface

// *** core/hwh_host.sv ***
// host end of the wake-up / ready handshake
// assumes the host's own link logic frames commands and honours ready_o
`timescale 1ns/1ps
module hwh_host #(
	parameter int unsigned PD_SETTLE = hwh_pkg::PD_SETTLE_CYC, // device sleep entry
	parameter int unsigned OSC_START = hwh_pkg::OSC_START_CYC, // device oscillator start
	parameter int unsigned ACK_PULSE = hwh_pkg::ACK_PULSE_CYC // acknowledge pulse width
) (
	input wire logic sys_clk_i, // system clock
	input wire logic resetn_i, // async reset, active low
	hwh_if.host link, // handshake lines
	input wire logic wake_i, // pulse: wake the device before a command
	input wire logic pd_cmd_i, // pulse: a sleep-causing command was answered
	input wire logic use_req_i, // level: acknowledge interrupts on the request line
	input wire logic low_batt_i, // level: device is in low-battery mode
	output logic ready_o, // level: a command may be sent now
	output logic irq_event_o, // pulse: interrupt line fell
	output logic irq_level_o // level: interrupt line held low
);
	import hwh_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		HS_IDLE = 4'b0001,
		HS_WAKE = 4'b0010,
		HS_HOLD = 4'b0100,
		HS_ACK = 4'b1000
	} hwh_host_state_e;

	typedef struct packed {
		hwh_host_state_e st;
		logic [CNT_W-1:0] cnt;
		logic irq_s1;
		logic irq_s2;
		logic irq_prev;
		logic req_n;
		logic ready;
		logic irq_event;
		logic irq_level;
	} hwh_host_s;

	hwh_host_s q;
	hwh_host_s d;
	logic irq_fall;

	function automatic logic [CNT_W-1:0] cnt_load(input int unsigned cycles);
		cnt_load = CNT_W'(cycles - 1);
	endfunction

	assign irq_fall = q.irq_prev & ~q.irq_s2;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.irq_event = 1'b0;
		d.irq_s1 = link.host_irq_n;
		d.irq_s2 = q.irq_s1;
		d.irq_prev = q.irq_s2;
		d.irq_level = ~q.irq_s2;
		if (q.cnt != '0) begin
			d.cnt = q.cnt - 1'b1;
		end
		if (irq_fall && !low_batt_i) begin
			d.irq_event = 1'b1;
		end
		case (q.st)
			HS_IDLE: begin
				if (irq_fall && use_req_i && !low_batt_i) begin
					d.req_n = LINE_ASSERTED;
					d.cnt = cnt_load(ACK_PULSE);
					d.st = HS_ACK;
				end else if (pd_cmd_i) begin
					d.ready = 1'b0;
					d.cnt = cnt_load(PD_SETTLE);
					d.st = HS_HOLD;
				end else if (wake_i && !low_batt_i) begin
					d.req_n = LINE_ASSERTED;
					d.ready = 1'b0;
					d.cnt = cnt_load(OSC_START);
					d.st = HS_WAKE;
				end
			end
			HS_WAKE: begin
				if (q.cnt == '0) begin
					d.req_n = LINE_RELEASED;
					d.ready = 1'b1;
					d.st = HS_IDLE;
				end
			end
			HS_HOLD: begin
				if (q.cnt == '0) begin
					d.ready = 1'b1;
					d.st = HS_IDLE;
				end
			end
			HS_ACK: begin
				// short pulse leaves the line idle high for the next edge
				if (q.cnt == '0) begin
					d.req_n = LINE_RELEASED;
					d.st = HS_IDLE;
				end
			end
			default: begin
				d.req_n = LINE_RELEASED;
				d.st = HS_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// request line idle high
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q.st <= HS_IDLE;
			q.cnt <= '0;
			q.irq_s1 <= LINE_RELEASED;
			q.irq_s2 <= LINE_RELEASED;
			q.irq_prev <= LINE_RELEASED;
			q.req_n <= LINE_RELEASED;
			q.ready <= 1'b1;
			q.irq_event <= 1'b0;
			q.irq_level <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign link.wake_req_n = q.req_n;
	assign ready_o = q.ready;
	assign irq_event_o = q.irq_event;
	assign irq_level_o = q.irq_level;

endmodule

// *** testbench/hwh_line_monitor.sv ***
// checker on the two handshake lines between device and host
// assumes it sits beside the interface, on the same clock and reset
`timescale 1ns/1ps
module hwh_line_monitor #(
	parameter int unsigned RESP_TIMEOUT = 20, // interrupt timeout
	parameter int unsigned OSC_START = 8, // wake pulse width
	parameter int unsigned ACK_PULSE = 4 // acknowledge pulse width
) (
	input wire logic sys_clk_i, // system clock
	input wire logic resetn_i, // async reset, active low
	input wire logic host_irq_n, // device request line
	input wire logic wake_req_n // host wake / acknowledge line
);
	int unsigned irq_low_q;
	int unsigned req_low_q;
	logic ack_q;

	// ------------------------------------------------------------
	// run lengths; ack_q remembers whether req fell as an ack
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_low_q <= 0;
			req_low_q <= 0;
			ack_q <= 1'b0;
		end else begin
			irq_low_q <= host_irq_n ? 0 : irq_low_q + 1;
			req_low_q <= wake_req_n ? 0 : req_low_q + 1;
			if (!wake_req_n && req_low_q == 0) begin
				ack_q <= !host_irq_n;
			end
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	// ------------------------------------------------------------
	// acknowledge steps
	// ------------------------------------------------------------
	sequence ack_fall;
		$fell(wake_req_n) && !host_irq_n;
	endsequence
	sequence irq_release;
		##[1:4] host_irq_n;
	endsequence

	reset_lines_a: assert property ($rose(resetn_i) |-> host_irq_n && wake_req_n)
		else $error("lines not idle high after reset");
	ack_release_a: assert property (ack_fall |-> irq_release)
		else $error("interrupt not released after acknowledge");
	irq_bound_a: assert property (irq_low_q <= RESP_TIMEOUT + 1)
		else $error("interrupt held low past timeout");
	pulse_width_a: assert property ($rose(wake_req_n) |->
		req_low_q == (ack_q ? ACK_PULSE : OSC_START))
		else $error("request pulse has wrong width");
	req_cap_a: assert property (req_low_q <= OSC_START)
		else $error("request line held low too long");
	irq_hold_a: assert property ($fell(host_irq_n) |-> !host_irq_n [*4])
		else $error("interrupt pulse too short");
	wake_quiet_a: assert property ($fell(wake_req_n) && host_irq_n |-> host_irq_n [*3])
		else $error("interrupt during wake pulse");
	ack_late_a: assert property (ack_fall |-> !$past(host_irq_n, 2))
		else $error("acknowledge without interrupt");
endmodule

// *** testbench/testbench.sv ***
// self-checking bench: both handshake ends joined by one interface
// assumes shortened counts; all inputs driven on the falling edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
	import hwh_pkg::*;
	localparam int unsigned TMO = 20;
	localparam int unsigned SETTLE = 10;
	localparam int unsigned OSC = 8;
	localparam int unsigned ACKW = 4;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic cmd_ack_i = 1'b0, rf_field_i = 1'b0, link_rx_i = 1'b0, resp_ready_i = 1'b0;
	logic sam_event_i = 1'b0, wake_i = 1'b0, pd_cmd_i = 1'b0, use_req_i = 1'b1;
	logic low_batt_i = 1'b0;
	hwh_cmd_e cmd_kind_i = HWH_CMD_OTHER;
	logic resp_send_o, asleep_o, low_batt_o, vcard_o, ready_o, irq_event_o, irq_level_o;
	int error_cnt = 0;
	int num_checks = 0;
	int n;
	hwh_cmd_e kinds [4] = '{HWH_CMD_TARGET_INIT, HWH_CMD_SAM_CARDEMU, HWH_CMD_POWER_DOWN,
		HWH_CMD_CPU_PD_VAR};

	hwh_if link_if ();
	always #2 sys_clk_i = ~sys_clk_i;

	hwh_device #(.RESP_TIMEOUT(TMO), .PD_SETTLE(SETTLE), .OSC_START(OSC)) i_hwh_device (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .link(link_if.dev),
		.cmd_ack_i(cmd_ack_i), .cmd_kind_i(cmd_kind_i), .rf_field_i(rf_field_i),
		.link_rx_i(link_rx_i), .resp_ready_i(resp_ready_i), .sam_event_i(sam_event_i),
		.resp_send_o(resp_send_o), .asleep_o(asleep_o), .low_batt_o(low_batt_o),
		.vcard_o(vcard_o));
	hwh_host #(.PD_SETTLE(SETTLE), .OSC_START(OSC), .ACK_PULSE(ACKW)) i_hwh_host (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .link(link_if.host), .wake_i(wake_i),
		.pd_cmd_i(pd_cmd_i), .use_req_i(use_req_i), .low_batt_i(low_batt_i),
		.ready_o(ready_o), .irq_event_o(irq_event_o), .irq_level_o(irq_level_o));
	hwh_line_monitor #(.RESP_TIMEOUT(TMO), .OSC_START(OSC), .ACK_PULSE(ACKW)) i_hwh_line_monitor (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .host_irq_n(link_if.host_irq_n),
		.wake_req_n(link_if.wake_req_n));

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// one-hot select: 4 resp, 3 link, 2 sam, 1 wake, 0 pd
	task automatic pulse(input int sel);
		{resp_ready_i, link_rx_i, sam_event_i, wake_i, pd_cmd_i} = 5'h01 << sel;
		@(negedge sys_clk_i);
		{resp_ready_i, link_rx_i, sam_event_i, wake_i, pd_cmd_i} = 5'h00;
	endtask
	task automatic ack(input hwh_cmd_e k, input logic fld);
		rf_field_i = fld;
		cmd_kind_i = k;
		cmd_ack_i = 1'b1;
		@(negedge sys_clk_i);
		cmd_ack_i = 1'b0;
	endtask
	// counts edges until the watched output (0 asleep, 1 send, 2 ready) shows lvl
	task automatic wait_lvl(input int sel, input logic lvl, output int cnt);
		cnt = 1;
		while ((sel == 0 ? asleep_o : sel == 1 ? resp_send_o : ready_o) !== lvl && cnt < 200) begin
			@(negedge sys_clk_i);
			cnt++;
		end
		if (cnt >= 200) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	// the design may land one edge late with respect to the nominal count
	task automatic chk_win(input string nm, input int cnt, input int lo);
		`CHK(nm, 1'b1, cnt >= lo && cnt <= lo + 1)
	endtask

	initial begin
		repeat (4) @(negedge sys_clk_i);
		resetn_i = 1'b1;
		@(negedge sys_clk_i);
		`CHK("irq idle", 1'b1, link_if.host_irq_n)
		`CHK("req idle", 1'b1, link_if.wake_req_n)
		`CHK("ready", 1'b1, ready_o)
		`CHK("preamble byte", 8'h00, PREAMBLE_BYTE)
		$display("test reset done");
		// no acknowledge: response goes out on timeout
		use_req_i = 1'b0;
		pulse(4);
		wait_lvl(1, 1'b1, n);
		chk_win("timeout send", n, TMO + 1);
		use_req_i = 1'b1;
		$display("test timeout done");
		// four sleep commands (not the low-battery or virtual-card ones), then wake by link data
		foreach (kinds[i]) begin
			ack(kinds[i], 1'b0);
			wait_lvl(0, 1'b1, n);
			chk_win("sleep entry", n, SETTLE + 1);
			pulse(3);
			wait_lvl(0, 1'b0, n);
			chk_win("link wake", n, OSC + 1);
		end
		ack(HWH_CMD_TARGET_INIT, 1'b1);
		repeat (SETTLE + 4) @(negedge sys_clk_i);
		`CHK("field keeps awake", 1'b0, asleep_o)
		$display("test sleep done");
		// host holds off commands while the device settles
		pulse(0);
		wait_lvl(2, 1'b1, n);
		chk_win("host settle", n, SETTLE + 1);
		// host wakes the device through the request line
		ack(HWH_CMD_POWER_DOWN, 1'b0);
		wait_lvl(0, 1'b1, n);
		pulse(1);
		wait_lvl(0, 1'b0, n);
		chk_win("req wake", n, OSC + 4);
		`CHK("ready after wake", 1'b1, ready_o)
		$display("test host wake done");
		// target activation while asleep, host acknowledges
		ack(HWH_CMD_TARGET_INIT, 1'b0);
		wait_lvl(0, 1'b1, n);
		pulse(4);
		`CHK("awake on resp", 1'b0, asleep_o)
		`CHK("irq low", 1'b0, link_if.host_irq_n)
		wait_lvl(1, 1'b1, n);
		`CHK("ack before timeout", 1'b1, n < TMO)
		@(negedge sys_clk_i);
		`CHK("irq released", 1'b1, link_if.host_irq_n)
		repeat (8) @(negedge sys_clk_i);
		$display("test target done");
		// low-battery: no interrupt, request line unused
		ack(HWH_CMD_SAM_LOWBAT, 1'b1);
		`CHK("low batt flag", 1'b1, low_batt_o)
		low_batt_i = 1'b1;
		pulse(4);
		`CHK("no irq low batt", 1'b1, link_if.host_irq_n)
		wait_lvl(1, 1'b1, n);
		`CHK("direct send", 1'b1, n <= 2)
		pulse(1);
		`CHK("no wake pulse", 1'b1, link_if.wake_req_n)
		low_batt_i = 1'b0;
		ack(HWH_CMD_SAM_CARDEMU, 1'b1);
		`CHK("low batt clear", 1'b0, low_batt_o)
		$display("test low battery done");
		// virtual card: secure event interrupt cleared by status query
		use_req_i = 1'b0;
		ack(HWH_CMD_SAM_VCARD, 1'b1);
		`CHK("vcard flag", 1'b1, vcard_o)
		pulse(2);
		// host event pulse: two sync stages plus the edge register
		repeat (2) @(negedge sys_clk_i);
		`CHK("no early event", 1'b0, irq_event_o)
		@(negedge sys_clk_i);
		`CHK("irq event", 1'b1, irq_event_o)
		@(negedge sys_clk_i);
		`CHK("event one cycle", 1'b0, irq_event_o)
		@(negedge sys_clk_i);
		`CHK("sam irq", 1'b0, link_if.host_irq_n)
		`CHK("host sees irq", 1'b1, irq_level_o)
		ack(HWH_CMD_STATUS_QUERY, 1'b1);
		@(negedge sys_clk_i);
		`CHK("sam irq cleared", 1'b1, link_if.host_irq_n)
		ack(HWH_CMD_POWER_DOWN, 1'b0);
		`CHK("vcard off", 1'b0, vcard_o)
		$display("test virtual card done");
		give_verdict();
	end
endmodule
